// ==== rtl/fsm_status_ctrl.sv ====
// floating status word, mode bits, exception registers and host outputs
`timescale 1ns/10ps
// Operation
// - second range test at minus one continues
// - positive source: shifted value sent directly
// - result msb differing from sign flags error
// - load status replaces whole status word
// - status word holds enables, modes, codes
// - store status returns all sixteen bits
// - register mode stores code only
// - memory mode: code word, then address
// - host traps to 244, reads exception status
// - copy floating codes to host codes
// - single precision clears bit 7
// - double precision sets bit 7
// - short integer clears bit 6
// - long integer sets bit 6
// - console shows microprogram counter 0-10
// - conversion trap only when enabled
// - negative source: two's complement the integer
module fsm_status_ctrl (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  input wire logic op_valid_i,
  input wire logic [3:0] op_code_i,
  input wire logic mode0_i,
  input wire logic [15:0] op_data_i,
  input wire logic [15:0] op_pc_i,
  input wire logic conv_sign_i,
  input wire logic [7:0] conv_exp_i,
  input wire logic [31:0] conv_frac_i,
  input wire logic console_upc_sel_i,
  input wire logic [10:0] upc_i,
  output logic wr_valid_o,
  output logic [15:0] wr_data_o,
  output logic wr_last_o,
  output logic [31:0] conv_result_o,
  output logic conv_error_o,
  output logic host_cc_valid_o,
  output logic [3:0] host_cc_o,
  output logic trap_o,
  output logic [8:0] trap_vector_o,
  output logic double_mode_o,
  output logic long_mode_o,
  output logic [10:0] console_upc_o,
  output logic busy_o
);
  typedef enum logic [1:0] {ST_IDLE, ST_CONV, ST_EXC_ADDR} fsm_state_e;
  fsm_state_e state_q, state_d;
  logic [15:0] status_q, status_d;
  logic [3:0] exc_code_q, exc_code_d;
  logic [15:0] exc_addr_q, exc_addr_d;
  logic busy_q, busy_d;
  logic [8:0] vec_q, vec_d;
  logic [15:0] conv_pc_q, conv_pc_d;
  logic wr_valid_q, wr_valid_d;
  logic [15:0] wr_data_q, wr_data_d;
  logic wr_last_q, wr_last_d;
  logic [31:0] conv_result_q, conv_result_d;
  logic conv_error_q, conv_error_d;
  logic cc_valid_q, cc_valid_d;
  logic [3:0] cc_q, cc_d;
  logic trap_q, trap_d;
  logic [10:0] upc_q, upc_d;
  logic start_q, start_d;
  logic c_long_q, c_long_d;
  logic c_sign_q, c_sign_d;
  logic [7:0] c_exp_q, c_exp_d;
  logic [31:0] c_frac_q, c_frac_d;
  fsm_pkg::fsm_op_e op;
  fsm_conv_if cv ();
  fsm_convert u_convert (
    .mclk_i(mclk_i),
    .resetn_i(resetn_i),
    .ce_i(ce_i),
    .cv(cv)
  );
  assign cv.start = start_q;
  assign cv.long_mode = c_long_q;
  assign cv.sign = c_sign_q;
  assign cv.exponent = c_exp_q;
  assign cv.fraction = c_frac_q;
  always_comb begin
    op = fsm_pkg::fsm_op_e'(op_code_i);
    state_d = state_q;
    status_d = status_q;
    exc_code_d = exc_code_q;
    exc_addr_d = exc_addr_q;
    // vector kept in a register so every output leaves a flip-flop
    vec_d = fsm_pkg::TRAP_VECTOR;
    conv_pc_d = conv_pc_q;
    wr_valid_d = 1'b0;
    wr_data_d = wr_data_q;
    wr_last_d = 1'b0;
    conv_result_d = conv_result_q;
    conv_error_d = 1'b0;
    cc_valid_d = 1'b0;
    cc_d = cc_q;
    trap_d = 1'b0;
    start_d = 1'b0;
    c_long_d = c_long_q;
    c_sign_d = c_sign_q;
    c_exp_d = c_exp_q;
    c_frac_d = c_frac_q;
    // console display only while selected; it freezes otherwise
    upc_d = console_upc_sel_i ? upc_i : upc_q;
    unique case (state_q)
      ST_IDLE: begin
        if (op_valid_i) begin
          // status bits not touched below keep their value
          case (op)
            fsm_pkg::FSM_OP_LOAD_STATUS: status_d = op_data_i;
            fsm_pkg::FSM_OP_STORE_STATUS: begin
              wr_valid_d = 1'b1;
              wr_data_d = status_q;
              wr_last_d = 1'b1;
            end
            fsm_pkg::FSM_OP_STORE_EXC: begin
              wr_valid_d = 1'b1;
              wr_data_d = {12'h000, exc_code_q};
              wr_last_d = mode0_i;
              if (!mode0_i) begin
                state_d = ST_EXC_ADDR;
              end
            end
            fsm_pkg::FSM_OP_COPY_CC: begin
              cc_valid_d = 1'b1;
              // order n, z, v, c onto the host's n, z, v, c
              cc_d = {status_q[fsm_pkg::SW_NEGATIVE], status_q[fsm_pkg::SW_ZERO],
                status_q[fsm_pkg::SW_OVERFLOW], status_q[fsm_pkg::SW_CARRY]};
            end
            fsm_pkg::FSM_OP_SEL_SINGLE: status_d[fsm_pkg::SW_DOUBLE] = 1'b0;
            fsm_pkg::FSM_OP_SEL_DOUBLE: status_d[fsm_pkg::SW_DOUBLE] = 1'b1;
            fsm_pkg::FSM_OP_SEL_SHORT: status_d[fsm_pkg::SW_LONG_INT] = 1'b0;
            fsm_pkg::FSM_OP_SEL_LONG: status_d[fsm_pkg::SW_LONG_INT] = 1'b1;
            fsm_pkg::FSM_OP_CONVERT: begin
              start_d = 1'b1;
              c_long_d = status_q[fsm_pkg::SW_LONG_INT];
              c_sign_d = conv_sign_i;
              c_exp_d = conv_exp_i;
              c_frac_d = conv_frac_i;
              conv_pc_d = op_pc_i;
              state_d = ST_CONV;
            end
            default: begin
            end
          endcase
        end
      end
      ST_CONV: begin
        // start lands in the unit one cycle later; done follows it
        if (cv.done) begin
          state_d = ST_IDLE;
          conv_result_d = cv.result;
          conv_error_d = cv.error;
          if (cv.error) begin
            status_d[fsm_pkg::SW_ERROR] = 1'b1;
            exc_code_d = fsm_pkg::EXC_CODE_CONV;
            exc_addr_d = conv_pc_q;
            if (cv.result == 32'h0000_0000) begin
              status_d[fsm_pkg::SW_ZERO] = 1'b1;
            end
            trap_d = status_q[fsm_pkg::SW_CONV_TRAP];
          end
        end
      end
      ST_EXC_ADDR: begin
        wr_valid_d = 1'b1;
        wr_data_d = exc_addr_q;
        wr_last_d = 1'b1;
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
    // busy registered from the next state so the port leaves a flip-flop
    busy_d = (state_d != ST_IDLE);
  end
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_q <= ST_IDLE;
      status_q <= fsm_pkg::SW_RESET;
      exc_code_q <= fsm_pkg::EXC_CODE_NONE;
      exc_addr_q <= 16'h0000;
      busy_q <= 1'b0;
      vec_q <= fsm_pkg::TRAP_VECTOR;
      conv_pc_q <= 16'h0000;
      wr_valid_q <= 1'b0;
      wr_data_q <= 16'h0000;
      wr_last_q <= 1'b0;
      conv_result_q <= 32'h0000_0000;
      conv_error_q <= 1'b0;
      cc_valid_q <= 1'b0;
      cc_q <= 4'h0;
      trap_q <= 1'b0;
      upc_q <= 11'h000;
      start_q <= 1'b0;
      c_long_q <= 1'b0;
      c_sign_q <= 1'b0;
      c_exp_q <= 8'h00;
      c_frac_q <= 32'h0000_0000;
    end else if (ce_i) begin
      state_q <= state_d;
      status_q <= status_d;
      exc_code_q <= exc_code_d;
      exc_addr_q <= exc_addr_d;
      busy_q <= busy_d;
      vec_q <= vec_d;
      conv_pc_q <= conv_pc_d;
      wr_valid_q <= wr_valid_d;
      wr_data_q <= wr_data_d;
      wr_last_q <= wr_last_d;
      conv_result_q <= conv_result_d;
      conv_error_q <= conv_error_d;
      cc_valid_q <= cc_valid_d;
      cc_q <= cc_d;
      trap_q <= trap_d;
      upc_q <= upc_d;
      start_q <= start_d;
      c_long_q <= c_long_d;
      c_sign_q <= c_sign_d;
      c_exp_q <= c_exp_d;
      c_frac_q <= c_frac_d;
    end
  end
  assign wr_valid_o = wr_valid_q;
  assign wr_data_o = wr_data_q;
  assign wr_last_o = wr_last_q;
  assign conv_result_o = conv_result_q;
  assign conv_error_o = conv_error_q;
  assign host_cc_valid_o = cc_valid_q;
  assign host_cc_o = cc_q;
  assign trap_o = trap_q;
  assign trap_vector_o = vec_q;
  assign double_mode_o = status_q[fsm_pkg::SW_DOUBLE];
  assign long_mode_o = status_q[fsm_pkg::SW_LONG_INT];
  assign console_upc_o = upc_q;
  assign busy_o = busy_q;
endmodule : fsm_status_ctrl

// ==== inc/fsm_pkg.sv ====
// package for the floating status and mode control block
package fsm_pkg;
  localparam int unsigned WORD_W = 16;
  localparam int unsigned LONG_W = 32;
  localparam int unsigned SHORT_W = 16;
  localparam int unsigned UPC_W = 11;
  localparam int unsigned EXC_CODE_W = 4;
  localparam int unsigned EXP_W = 8;
  // status word field positions
  localparam int unsigned SW_CARRY = 0;
  localparam int unsigned SW_OVERFLOW = 1;
  localparam int unsigned SW_ZERO = 2;
  localparam int unsigned SW_NEGATIVE = 3;
  localparam int unsigned SW_TRUNCATE = 5;
  localparam int unsigned SW_LONG_INT = 6;
  localparam int unsigned SW_DOUBLE = 7;
  localparam int unsigned SW_UNDEF_TRAP = 9;
  localparam int unsigned SW_CONV_TRAP = 10;
  localparam int unsigned SW_ERROR = 15;
  localparam logic [15:0] SW_RESET = 16'h0000;
  // conversion constants, octal 201, 20, 40
  localparam logic [8:0] EXP_ONE = 9'h081;
  localparam logic [8:0] RANGE_SHORT = 9'h010;
  localparam logic [8:0] RANGE_LONG = 9'h020;
  localparam logic [8:0] MINUS_ONE = 9'h1ff;
  // exception codes
  localparam logic [3:0] EXC_CODE_CONV = 4'h6;
  localparam logic [3:0] EXC_CODE_NONE = 4'h0;
  // host trap vector, octal 244
  localparam logic [8:0] TRAP_VECTOR = 9'h0a4;
  typedef enum logic [3:0] {
    FSM_OP_NONE,
    FSM_OP_LOAD_STATUS,
    FSM_OP_STORE_STATUS,
    FSM_OP_STORE_EXC,
    FSM_OP_COPY_CC,
    FSM_OP_SEL_SINGLE,
    FSM_OP_SEL_DOUBLE,
    FSM_OP_SEL_SHORT,
    FSM_OP_SEL_LONG,
    FSM_OP_CONVERT
  } fsm_op_e;
endpackage : fsm_pkg

// ==== inc/fsm_conv_if.sv ====
// interface joining the controller and the convert unit
`timescale 1ns/10ps
interface fsm_conv_if;
  logic start;
  logic long_mode;
  logic sign;
  logic [7:0] exponent;
  logic [31:0] fraction;
  logic done;
  logic error;
  logic [31:0] result;
  modport ctrl (output start, output long_mode, output sign, output exponent,
    output fraction, input done, input error, input result);
  modport unit (input start, input long_mode, input sign, input exponent,
    input fraction, output done, output error, output result);
endinterface : fsm_conv_if

// ==== rtl/fsm_convert.sv ====
// float to integer convert unit with three range tests
`timescale 1ns/10ps
module fsm_convert (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  fsm_conv_if.unit cv
);
  logic done_q, done_d;
  logic error_q, error_d;
  logic [31:0] result_q, result_d;
  logic [8:0] t1;
  logic [8:0] t2;
  logic [8:0] shifts;
  logic [31:0] shifted;
  logic [31:0] final_int;
  logic msb;
  always_comb begin
    t1 = {1'b0, cv.exponent} - fsm_pkg::EXP_ONE;
    t2 = t1 - (cv.long_mode ? fsm_pkg::RANGE_LONG : fsm_pkg::RANGE_SHORT);
    shifts = 9'h000 - t2 - 9'h001;
    shifted = (shifts > 9'h01f) ? 32'h0000_0000 : (cv.fraction >> shifts[4:0]);
    if (!cv.long_mode) begin
      shifted = shifted >> fsm_pkg::SHORT_W;
    end
    // positive values go out as shifted, negative ones are complemented
    final_int = cv.sign ? (32'h0000_0000 - shifted) : shifted;
    msb = cv.long_mode ? final_int[31] : final_int[15];
    done_d = cv.start;
    error_d = error_q;
    result_d = result_q;
    if (cv.start) begin
      if (t1[8]) begin
        error_d = 1'b1;
        result_d = 32'h0000_0000;
      end else if (!t2[8]) begin
        error_d = 1'b1;
        result_d = 32'h0000_0000;
      end else begin
        // t2 of minus one passes on, the sign test catches it
        error_d = (msb != cv.sign);
        result_d = cv.long_mode ? final_int : {16'h0000, final_int[15:0]};
      end
    end
  end
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      done_q <= 1'b0;
      error_q <= 1'b0;
      result_q <= 32'h0000_0000;
    end else if (ce_i) begin
      done_q <= done_d;
      error_q <= error_d;
      result_q <= result_d;
    end
  end
  assign cv.done = done_q;
  assign cv.error = error_q;
  assign cv.result = result_q;
endmodule : fsm_convert

// ==== sim/fsm_chk.sv ====
// port assertions for the status and mode controller
`timescale 1ns/10ps
module fsm_chk (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  input wire logic op_valid_i,
  input wire logic [3:0] op_code_i,
  input wire logic mode0_i,
  input wire logic [15:0] op_data_i,
  input wire logic console_upc_sel_i,
  input wire logic [10:0] upc_i,
  input wire logic wr_valid_o,
  input wire logic [15:0] wr_data_o,
  input wire logic wr_last_o,
  input wire logic conv_error_o,
  input wire logic trap_o,
  input wire logic double_mode_o,
  input wire logic long_mode_o,
  input wire logic [10:0] console_upc_o,
  input wire logic busy_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);
  logic tk;
  assign tk = ce_i && op_valid_i && !busy_o;
  sequence s_code;
    wr_valid_o && !wr_last_o && wr_data_o[15:4] == 12'h000;
  endsequence
  sequence s_addr;
    wr_valid_o && wr_last_o;
  endsequence
  a_exc_mem_order: assert property (tk && op_code_i == 4'h3 && !mode0_i
    |=> s_code ##1 s_addr) else $error("memory exception store words wrong");
  a_exc_code_only: assert property (tk && op_code_i == 4'h3 && mode0_i
    |=> wr_valid_o && wr_last_o && wr_data_o[15:4] == 12'h000 ##1 !wr_valid_o)
    else $error("code only");
  a_load_word: assert property (tk && op_code_i == 4'h1
    |=> double_mode_o == $past(op_data_i[7]) && long_mode_o == $past(op_data_i[6]))
    else $error("load status modes wrong");
  a_store_word: assert property (tk && op_code_i == 4'h2 |=> wr_valid_o
    && wr_data_o[7] == double_mode_o && wr_data_o[6] == long_mode_o) else $error("store status");
  a_prec_set: assert property (tk && (op_code_i == 4'h5 || op_code_i == 4'h6)
    |=> double_mode_o == !$past(op_code_i[0])) else $error("precision bit wrong");
  a_int_set: assert property (tk && (op_code_i == 4'h7 || op_code_i == 4'h8)
    |=> long_mode_o == $past(op_code_i[3])) else $error("integer length bit wrong");
  a_modes_hold: assert property (!tk |=> $stable(double_mode_o) && $stable(long_mode_o))
    else $error("mode bits moved");
  a_trap_gate: assert property (trap_o |-> conv_error_o) else $error("trap without error");
  a_upc_follow: assert property (console_upc_sel_i && ce_i |=> console_upc_o == $past(upc_i))
    else $error("console counter lags");
endmodule : fsm_chk
bind fsm_status_ctrl fsm_chk u_chk (.*);

// ==== sim/fsm_host_model.sv ====
// host side: takes destination words, condition codes and trap vectors
`timescale 1ns/10ps
module fsm_host_model (
  input wire logic mclk_i,
  input wire logic wr_valid_i,
  input wire logic [15:0] wr_data_i,
  input wire logic cc_valid_i,
  input wire logic [3:0] cc_i,
  input wire logic trap_i,
  input wire logic [8:0] vec_i
);
  logic [15:0] words[$];
  logic [3:0] cpu_cc = 4'h0;
  logic [8:0] vec_seen = 9'h000;
  always @(posedge mclk_i) begin
    if (wr_valid_i === 1'b1) words.push_back(wr_data_i);
    if (cc_valid_i === 1'b1) cpu_cc <= cc_i;
    if (trap_i === 1'b1) vec_seen <= vec_i;
  end
endmodule : fsm_host_model

// ==== sim/testbench.sv ====
// self-checking bench for the status and mode controller
`timescale 1ns/10ps
module testbench;
  logic mclk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic ce_i = 1'b1;
  logic op_valid_i = 1'b0;
  logic [3:0] op_code_i = 4'h0;
  logic mode0_i = 1'b0;
  logic [15:0] op_data_i = 16'h0000;
  logic [15:0] op_pc_i = 16'h0000;
  logic conv_sign_i = 1'b0;
  logic [7:0] conv_exp_i = 8'h00;
  logic [31:0] conv_frac_i = 32'h00000000;
  logic console_upc_sel_i = 1'b0;
  logic [10:0] upc_i = 11'h000;
  logic wr_valid_o, wr_last_o, conv_error_o, host_cc_valid_o, trap_o, double_mode_o;
  logic long_mode_o, busy_o;
  logic [15:0] wr_data_o;
  logic [31:0] conv_result_o;
  logic [3:0] host_cc_o;
  logic [8:0] trap_vector_o;
  logic [10:0] console_upc_o;
  int failures = 0;
  int samples_checked = 0;
  int cyc = 0;
  fsm_status_ctrl uut (.*);
  fsm_host_model host (.mclk_i(mclk_i), .wr_valid_i(wr_valid_o), .wr_data_i(wr_data_o),
    .cc_valid_i(host_cc_valid_o), .cc_i(host_cc_o), .trap_i(trap_o), .vec_i(trap_vector_o));
  initial begin
    forever #2.5 mclk_i = ~mclk_i;
  end
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      failures++;
      end_sim();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic end_sim();
    $display("checked %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_sim
  // entered just after an edge; returns once busy has dropped
  task automatic op(input logic [3:0] c, input logic [15:0] d);
    int n;
    n = 0;
    op_code_i = c;
    op_data_i = d;
    op_valid_i = 1'b1;
    @(posedge mclk_i);
    #1 op_valid_i = 1'b0;
    // one idle edge keeps the strobe from falling and rising in one step
    @(posedge mclk_i);
    #1 n = 0;
    while (busy_o !== 1'b0 && n < 20) begin
      @(posedge mclk_i);
      #1 n++;
    end
  endtask : op
  task automatic cvt(input logic s, input logic [7:0] x, input logic [31:0] f);
    conv_sign_i = s;
    conv_exp_i = x;
    conv_frac_i = f;
    op_pc_i = 16'($urandom);
    op(4'h9, 16'h0000);
  endtask : cvt
  initial begin
    logic [15:0] d;
    logic [31:0] n;
    int b;
    void'($urandom(32'hf8291711));
    repeat (2) @(posedge mclk_i);
    #1 resetn_i = 1'b1;
    chk("vector", 9'h0a4, trap_vector_o);
    repeat (6) begin
      d = 16'($urandom);
      op(4'h1, d);
      chk("modes", d[7:6], {double_mode_o, long_mode_o});
      op(4'h2, 16'h0000);
      chk("status", d, wr_data_o);
      op(4'h4, 16'h0000);
      chk("cc", d[3:0], host_cc_o);
      chk("hostcc", d[3:0], host.cpu_cc);
    end
    for (int k = 5; k <= 8; k++) begin
      op(4'(k), 16'h0000);
      repeat (3) op(4'h0, 16'h0000);
      if (k < 7) chk("prec", k == 6, double_mode_o);
      else chk("intlen", k == 8, long_mode_o);
    end
    chk("held", 2'b11, {double_mode_o, long_mode_o});
    op(4'h1, 16'h0400);
    repeat (4) begin
      n = ($urandom & 32'h3fff) | 32'h1;
      b = $clog2(n + 1);
      cvt(n[1], 8'h80 + 8'(b), n << (32 - b));
      chk("short", (n[1] ? -n : n) & 32'h0000ffff, conv_result_o);
      chk("error", 0, conv_error_o);
    end
    // test two gives minus one: the most negative short still converts
    cvt(1'b1, 8'h90, 32'h80000000);
    chk("short", 32'h00008000, conv_result_o);
    chk("error", 0, conv_error_o);
    // below one: error, zero result, zero flag set
    cvt(1'b0, 8'h80, 32'h80000000);
    chk("error", 1, conv_error_o);
    chk("zero", 0, conv_result_o);
    chk("trap", 1, trap_o);
    op(4'h4, 16'h0000);
    chk("cc", 4'h4, host_cc_o);
    op(4'h1, 16'h0440);
    repeat (6) begin
      n = ($urandom & 32'h3fffffff) | 32'h1;
      b = $clog2(n + 1);
      cvt(n[1], 8'h80 + 8'(b), n << (32 - b));
      chk("result", n[1] ? -n : n, conv_result_o);
      chk("error", 0, conv_error_o);
    end
    // one past the most positive long: only the sign test catches it
    cvt(1'b0, 8'ha0, 32'h80000000);
    chk("error", 1, conv_error_o);
    chk("trap", 1, trap_o);
    d = op_pc_i;
    host.words.delete();
    op(4'h3, 16'h0000);
    @(posedge mclk_i);
    #1 chk("words", {16'h0006, d}, {host.words[0], host.words[1]});
    chk("hostvec", 9'h0a4, host.vec_seen);
    op(4'h1, 16'h0040);
    cvt(1'b0, 8'ha0, 32'h80000000);
    chk("masked", 2'b10, {conv_error_o, trap_o});
    mode0_i = 1'b1;
    op(4'h3, 16'h0000);
    chk("code", 16'h0006, wr_data_o);
    console_upc_sel_i = 1'b1;
    upc_i = 11'($urandom);
    d = {5'h00, upc_i};
    @(posedge mclk_i);
    #1 console_upc_sel_i = 1'b0;
    chk("upc", d, console_upc_o);
    upc_i = ~upc_i;
    @(posedge mclk_i);
    #1 chk("upc", d, console_upc_o);
    // clock enable low freezes the display even while selected
    ce_i = 1'b0;
    console_upc_sel_i = 1'b1;
    @(posedge mclk_i);
    #1 chk("frozen", d, console_upc_o);
    ce_i = 1'b1;
    @(posedge mclk_i);
    #1 chk("upc", {5'h00, upc_i}, console_upc_o);
    end_sim();
  end
endmodule : testbench
